/* hw/flash_status_params.svh */
// opcodes, register addresses, frame bit counts and reset values
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// command opcodes
`define CMD_RD_STATUS 8'h05
`define CMD_RD_STATUS2 8'h07
`define CMD_RD_ANY 8'h65
`define CMD_WR_REGS 8'h01
`define CMD_WR_ANY 8'h71
`define CMD_WR_EN 8'h06
`define CMD_WR_DIS 8'h04
`define CMD_CLR_A 8'h30
`define CMD_CLR_B 8'h82
`define CMD_ERS_SUSP 8'h75
`define CMD_PGM_SUSP 8'h85
`define CMD_ANY_SUSP 8'hb0
`define CMD_PROGRAM 8'h02
`define CMD_SECT_ERASE 8'hd8
`define CMD_BULK_ERASE 8'h60
`define CMD_SOFT_RESET 8'hf0

// any-register addresses of the two status-one copies
`define ADDR_SR1_NV 24'h00_0000
`define ADDR_SR1_V 24'h80_0000

// edge index (from 0) on which a field of the frame is complete
`define EDGE_FIRST 6'h00
`define EDGE_OPCODE 6'h07
`define EDGE_DATA1 6'h0f
`define EDGE_ADDR 6'h1f
`define EDGE_WRITE_ANY_REGISTER_CMD_DATA 6'h27
`define EDGE_LAST 6'h3f
`define BYTE_END 3'h7

// bit counts of complete frames
`define BITS_OPCODE 6'h08
`define BITS_WRR 6'h10
`define BITS_WRR_CR 6'h18
`define BITS_ADDR 6'h20
`define BITS_WRITE_ANY_REGISTER_CMD 6'h28
`define BITS_MAX 6'h3f

// reset and factory default values
`define LOCK_RST 1'b0
`define P_ERR_DEF 1'b0
`define E_ERR_DEF 1'b0
`define BP_NV_RST 3'h0
`define WEL_DEF 1'b0
`define WIP_DEF 1'b0
`define CS_SYNC_RST 3'h7
`define WP_SYNC_RST 2'h3

`endif

/* hw/flash_status_pkg.sv */
// types shared by the status-one register block
package flash_status_pkg;

  // layout of a status-one byte, bit 7 first
  typedef struct packed {
    logic lock;
    logic p_err;
    logic e_err;
    logic [2:0] bp;
    logic write_latch_flag;
    logic busy;
  } status_s;

  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_ERASE,
    OP_BULK,
    OP_REG
  } op_kind_e;

  // request handed to the array / register engine
  typedef struct packed {
    op_kind_e kind;
    logic [23:0] addr;
  } op_req_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARRAY,
    ST_WREG,
    ST_ERROR
  } core_state_e;

  // state on the system clock
  typedef struct packed {
    logic [2:0] cs_sync;
    logic [1:0] wp_sync;
    logic [1:0] tgl_sync;
    logic tgl_seen;
    core_state_e st;
    status_s sr;
    logic [2:0] bp_nv;
    op_req_s req;
    logic op_start;
    logic suspend;
    logic pend;
    logic [7:0] fr_op;
    logic [7:0] fr_dat;
    logic [5:0] fr_bits;
    logic [23:0] fr_addr;
    status_s wr;
    logic wr_bp;
    logic [15:0] snap;
  } core_s;

  // bit position in the frame, cleared by chip select
  typedef struct packed {
    logic ovf;
    logic [5:0] cnt;
  } link_cnt_s;

  // state on the serial clock
  typedef struct packed {
    logic [7:0] sh;
    logic [23:0] addr;
    logic [7:0] op;
    logic [7:0] cap_dat;
    logic [23:0] cap_addr;
    logic [5:0] cap_bits;
    logic frm_tgl;
    logic [7:0] tx;
    logic [7:0] rd_word;
  } link_s;

endpackage

/* hw/flash_status_one.sv */
// volatile status register one with its serial command front end
`include "flash_status_params.svh"
`timescale 1ns/1ns
`default_nettype none

module flash_status_one
  import flash_status_pkg::*;
(
  input wire logic clk_i,                   // system clock
  input wire logic sys_rst_i,               // sync reset, active high
  input wire logic sck_i,                   // serial clock from host
  input wire logic cs_n_i,                  // chip select, active low
  input wire logic mosi_i,                  // serial data in
  output logic miso_o,                      // serial data out
  output logic miso_oe_n_o,                 // data out enable, low drives
  input wire logic wp_n_i,                  // write-protect pin
  input wire logic protect_source_select_i, // 1 = volatile protect bits
  input wire logic addr_protected_i,        // decode of check_addr_o
  input wire logic op_done_i,               // engine finished, pulse
  input wire logic op_fail_i,               // engine failed, with done
  output logic [23:0] check_addr_o,         // address under decode
  output logic [2:0] bp_active_o,           // protect bits in force
  output status_s status_o,                 // volatile status one
  output op_req_s op_req_o,                 // engine request
  output logic op_start_o,                  // engine start, pulse
  output logic suspend_o                    // suspend request, pulse
);

  ////////////////////////////////////////////////////////////////////
  // serial clock domain

  link_cnt_s c_q;
  link_cnt_s c_d;
  link_s l_q;
  link_s l_d;
  core_s q;
  core_s d;

  // frame position: chip select high ends the frame without sck edges
  always_comb begin
    c_d = c_q;
    c_d.cnt = c_q.cnt + 6'h01;
    c_d.ovf = c_q.ovf | (c_q.cnt == `EDGE_LAST);
  end

  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // capture of opcode, address and data; shift of read data
  always_comb begin
    logic [7:0] sh_new;
    logic [23:0] addr_new;
    logic early;
    logic byte_end;
    sh_new = {l_q.sh[6:0], mosi_i};
    addr_new = {l_q.addr[22:0], mosi_i};
    early = ~c_q.ovf;
    byte_end = (c_q.cnt[2:0] == `BYTE_END);
    l_d = l_q;
    l_d.sh = sh_new;
    l_d.addr = addr_new;
    l_d.cap_bits = c_d.ovf ? `BITS_MAX : c_d.cnt;
    // frame flag set opposite to the seen copy: needs no reset here
    if (early && c_q.cnt == `EDGE_FIRST) begin
      l_d.frm_tgl = ~q.tgl_seen;
    end
    if (early && c_q.cnt == `EDGE_OPCODE) begin
      l_d.op = sh_new;
    end
    if (early && (c_q.cnt == `EDGE_DATA1 ||
                  c_q.cnt == `EDGE_WRITE_ANY_REGISTER_CMD_DATA)) begin
      l_d.cap_dat = sh_new;
    end
    if (early && c_q.cnt == `EDGE_ADDR) begin
      l_d.cap_addr = addr_new;
      if (addr_new == `ADDR_SR1_V) begin
        l_d.rd_word = q.snap[7:0];
      end else if (addr_new == `ADDR_SR1_NV) begin
        l_d.rd_word = q.snap[15:8];
      end else begin
        l_d.rd_word = 8'h00;
      end
    end
    if (early && c_q.cnt == `EDGE_OPCODE) begin
      l_d.tx = (sh_new == `CMD_RD_STATUS) ? q.snap[7:0] : 8'h00;
    end else if (byte_end && l_q.op == `CMD_RD_STATUS) begin
      l_d.tx = q.snap[7:0];
    end else if (early && c_q.cnt == `EDGE_ADDR &&
                 l_q.op == `CMD_RD_ANY) begin
      l_d.tx = l_d.rd_word;
    end else if (byte_end && l_q.op == `CMD_RD_ANY &&
                 (c_q.ovf || c_q.cnt > `EDGE_ADDR)) begin
      l_d.tx = l_q.rd_word;
    end else begin
      l_d.tx = {l_q.tx[6:0], 1'b0};
    end
  end

  // data only, no reset: the system side reads it once the frame ends
  always_ff @(posedge sck_i) begin
    l_q <= l_d;
  end

  // out bit changes just after the rising edge, host samples the next
  assign miso_o = (~cs_n_i && (c_q.ovf || c_q.cnt > `EDGE_OPCODE)) ?
                  l_q.tx[7] : 1'b0;
  assign miso_oe_n_o = cs_n_i;

  ////////////////////////////////////////////////////////////////////
  // system clock domain

  always_comb begin
    logic frame_end;
    logic fresh;
    logic busy;
    logic locked;
    logic one_byte;
    logic [2:0] bp_act;
    status_s din;
    d = q;
    d.cs_sync = {q.cs_sync[1:0], cs_n_i};
    d.wp_sync = {q.wp_sync[0], wp_n_i};
    d.tgl_sync = {q.tgl_sync[0], l_q.frm_tgl};
    d.op_start = 1'b0;
    d.suspend = 1'b0;
    frame_end = q.cs_sync[1] & ~q.cs_sync[2];
    fresh = q.tgl_sync[1] ^ q.tgl_seen;
    busy = (q.st != ST_IDLE);
    locked = q.sr.lock & ~q.wp_sync[1];
    one_byte = (q.fr_bits == `BITS_OPCODE);
    bp_act = protect_source_select_i ? q.sr.bp : q.bp_nv;
    din = status_s'(q.fr_dat);

    // frame fields are stable here: sck has stopped with cs high
    if (frame_end && fresh) begin
      d.tgl_seen = q.tgl_sync[1];
      d.pend = 1'b1;
      d.fr_op = l_q.op;
      d.fr_dat = l_q.cap_dat;
      d.fr_bits = l_q.cap_bits;
      d.fr_addr = l_q.cap_addr;
    end
    // read word frozen while a frame is in progress
    if (q.cs_sync[1]) begin
      d.snap = {q.sr.lock, `P_ERR_DEF, `E_ERR_DEF, q.bp_nv,
                `WEL_DEF, `WIP_DEF, q.sr};
    end

    if (q.pend) begin
      d.pend = 1'b0;
      if ((q.fr_op == `CMD_CLR_A || q.fr_op == `CMD_CLR_B) && one_byte) begin
        d.sr.p_err = 1'b0;
        d.sr.e_err = 1'b0;
        if (q.st == ST_ERROR) begin
          d.st = ST_IDLE;
        end
      end else if (q.fr_op == `CMD_SOFT_RESET && one_byte) begin
        d.sr.write_latch_flag = `WEL_DEF;
        d.sr.p_err = `P_ERR_DEF;
        d.sr.e_err = `E_ERR_DEF;
        d.sr.bp = q.bp_nv;
        d.st = ST_IDLE;
      end else if (one_byte && q.st == ST_ARRAY &&
                   (q.fr_op == `CMD_ANY_SUSP ||
                    (q.fr_op == `CMD_ERS_SUSP && q.req.kind != OP_PROGRAM) ||
                    (q.fr_op == `CMD_PGM_SUSP && q.req.kind == OP_PROGRAM))) begin
        // suspend only a matching array operation
        d.suspend = 1'b1;
      end else if (!busy) begin
        unique case (q.fr_op)
          `CMD_WR_EN: begin
            if (one_byte) begin
              d.sr.write_latch_flag = 1'b1;
            end
          end
          `CMD_WR_DIS: begin
            if (one_byte) begin
              d.sr.write_latch_flag = 1'b0;
            end
          end
          `CMD_WR_REGS: begin
            // latch and lock gate the write
            if (q.sr.write_latch_flag && !locked && (q.fr_bits == `BITS_WRR ||
                                        q.fr_bits == `BITS_WRR_CR)) begin
              if (protect_source_select_i) begin
                d.sr.bp = din.bp;
                d.sr.write_latch_flag = 1'b0;
              end else begin
                d.wr = din;
                d.wr_bp = 1'b1;
                d.req.kind = OP_REG;
                d.op_start = 1'b1;
                d.st = ST_WREG;
              end
            end
          end
          `CMD_WR_ANY: begin
            // latch and lock gate the write
            if (q.sr.write_latch_flag && !locked && q.fr_bits == `BITS_WRITE_ANY_REGISTER_CMD) begin
              if (q.fr_addr == `ADDR_SR1_V) begin
                // volatile bits writable only with source 1
                if (protect_source_select_i) begin
                  d.sr.bp = din.bp;
                end
                d.sr.write_latch_flag = 1'b0;
              end else if (q.fr_addr == `ADDR_SR1_NV) begin
                d.wr = din;
                d.wr_bp = ~protect_source_select_i;
                d.req.kind = OP_REG;
                d.op_start = 1'b1;
                d.st = ST_WREG;
              end
            end
          end
          `CMD_PROGRAM: begin
            if (q.sr.write_latch_flag && q.fr_bits >= `BITS_ADDR) begin
              if (addr_protected_i) begin
                d.sr.p_err = 1'b1;
                d.st = ST_ERROR;
              end else begin
                d.req = '{kind: OP_PROGRAM, addr: q.fr_addr};
                d.op_start = 1'b1;
                d.st = ST_ARRAY;
              end
            end
          end
          `CMD_SECT_ERASE: begin
            if (q.sr.write_latch_flag && q.fr_bits == `BITS_ADDR) begin
              if (addr_protected_i) begin
                d.sr.e_err = 1'b1;
                d.st = ST_ERROR;
              end else begin
                d.req = '{kind: OP_ERASE, addr: q.fr_addr};
                d.op_start = 1'b1;
                d.st = ST_ARRAY;
              end
            end
          end
          `CMD_BULK_ERASE: begin
            // bulk erase only with no protect bit active
            if (q.sr.write_latch_flag && one_byte && bp_act == 3'h0) begin
              d.req = '{kind: OP_BULK, addr: 24'h00_0000};
              d.op_start = 1'b1;
              d.st = ST_ARRAY;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // engine completion; placed last so a failure beats a clear
    if ((q.st == ST_ARRAY || q.st == ST_WREG) && op_done_i) begin
      if (op_fail_i) begin
        d.st = ST_ERROR;
        if (q.st == ST_ARRAY && q.req.kind != OP_PROGRAM) begin
          // engine fail only, skipped sectors do not count
          d.sr.e_err = 1'b1;
        end else begin
          d.sr.p_err = 1'b1;
        end
      end else begin
        d.sr.write_latch_flag = 1'b0;
        d.st = ST_IDLE;
        if (q.st == ST_WREG) begin
          // lock copy follows the stored bit
          d.sr.lock = q.wr.lock;
          if (q.wr_bp) begin
            // stored and volatile protect bits equal
            d.bp_nv = q.wr.bp;
            d.sr.bp = q.wr.bp;
          end
        end
      end
    end
    // busy follows the operation state only
    d.sr.busy = (d.st != ST_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.cs_sync <= `CS_SYNC_RST;
      q.wp_sync <= `WP_SYNC_RST;
      q.st <= ST_IDLE;
      q.sr <= '{lock: `LOCK_RST, p_err: `P_ERR_DEF, e_err: `E_ERR_DEF,
                bp: `BP_NV_RST, write_latch_flag: `WEL_DEF, busy: `WIP_DEF};
      q.bp_nv <= `BP_NV_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state; bp_active_o picked by protect_source_select_i
  assign status_o = q.sr;
  assign bp_active_o = protect_source_select_i ? q.sr.bp : q.bp_nv;
  assign check_addr_o = q.fr_addr;
  assign op_req_o = q.req;
  assign op_start_o = q.op_start;
  assign suspend_o = q.suspend;

endmodule

`default_nettype wire

/* test/flash_status_one_props.sv */
// concurrent checks on the status-one block ports
`timescale 1ns/1ns
`default_nettype none

module flash_status_one_props
  import flash_status_pkg::*;
(
  input wire logic clk_i,           // system clock
  input wire logic sys_rst_i,       // sync reset
  input wire logic op_done_i,       // engine done
  input wire logic op_fail_i,       // engine fail
  input wire logic [2:0] bp_active_o, // protect bits in force
  input wire status_s status_o,     // status byte
  input wire op_req_s op_req_o,     // engine request
  input wire logic op_start_o,      // engine start
  input wire logic suspend_o        // suspend pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////
  // engine start and busy tracking
  a_busy_after_start: assert property (
    op_start_o |=> status_o.busy)
    else $error("busy not set after start");
  a_start_one_cycle: assert property (
    op_start_o |=> !op_start_o)
    else $error("start longer than one cycle");
  a_start_needs_wel: assert property (
    op_start_o |-> status_o.write_latch_flag)
    else $error("start without write latch");
  a_start_when_idle: assert property (
    op_start_o |-> !$past(status_o.busy))
    else $error("start accepted while busy");
  a_bulk_unprotected: assert property (
    op_start_o && op_req_o.kind == OP_BULK |-> bp_active_o == 3'h0)
    else $error("bulk erase with protect bits set");

  ////////////////////////////////////////////////////////////////////////
  // completion, failure and the busy hold
  a_done_clears_wel: assert property (
    status_o.busy && op_done_i && !op_fail_i |=>
    !status_o.write_latch_flag && !status_o.busy)
    else $error("latch or busy kept after success");
  a_erase_fail_flag: assert property (
    status_o.busy && op_done_i && op_fail_i &&
    op_req_o.kind == OP_ERASE |=> status_o.e_err)
    else $error("erase fail flag not set");
  a_prog_fail_flag: assert property (
    status_o.busy && op_done_i && op_fail_i &&
    op_req_o.kind == OP_PROGRAM |=> status_o.p_err)
    else $error("program fail flag not set");
  a_fail_holds_busy: assert property (
    status_o.p_err || status_o.e_err |-> status_o.busy)
    else $error("busy dropped with a fail flag set");
  a_suspend_busy: assert property (
    suspend_o |-> status_o.busy)
    else $error("suspend outside an operation");
endmodule

`default_nettype wire

/* test/spi_host_model.sv */
// serial host model: mode 0 frames, clock still between frames
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
  output logic sck_o,     // serial clock, 30 ns period in frames
  output logic cs_n_o,    // chip select, active low
  output logic mosi_o,    // serial data out
  input wire logic miso_i // serial data in
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one frame of n bits from the top of d; the last byte read comes back
  // mosi is inverted when released so a stale bit cannot look valid
  task automatic frame(input logic [39:0] d, input int n,
                       output logic [7:0] rd);
    rd = 8'h00;
    cs_n_o = 1'b0;
    #240;
    for (int i = 0; i < n; i++) begin
      mosi_o = d[39-i];
      #15;
      if (i >= 8) rd = {rd[6:0], miso_i};
      sck_o = 1'b1;
      #15;
      sck_o = 1'b0;
    end
    #15;
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #400;
  endtask
endmodule

`default_nettype wire

/* test/test_flash_status_one.sv */
// directed bench for the status-one block over its serial port
`include "flash_status_params.svh"
`timescale 1ns/1ns
`default_nettype none

module test_flash_status_one;
  import flash_status_pkg::*;
  logic clk_i, sys_rst_i, sck_i, cs_n_i, mosi_i, miso_o, wp_n_i;
  logic protect_source_select_i, addr_protected_i, op_done_i, op_fail_i;
  logic [2:0] bp_active_o;
  status_s status_o;
  op_req_s op_req_o;
  logic op_start_o, suspend_o;
  logic miso_oe_n_o;
  logic [23:0] check_addr_o;
  logic [7:0] rd_v, n_start, n_susp;
  int n_mismatch, num_checks;

  flash_status_one u_flash_status_one (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o), .wp_n_i(wp_n_i),
    .protect_source_select_i(protect_source_select_i),
    .addr_protected_i(addr_protected_i), .op_done_i(op_done_i),
    .op_fail_i(op_fail_i), .check_addr_o(check_addr_o),
    .bp_active_o(bp_active_o),
    .status_o(status_o), .op_req_o(op_req_o), .op_start_o(op_start_o),
    .suspend_o(suspend_o));
  spi_host_model host (.sck_o(sck_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i),
    .miso_i(miso_o));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // engine pulses are counted rather than polled, so none is missed
  always @(posedge clk_i) begin
    if (sys_rst_i === 1'b1) n_start <= 8'h00;
    else if (op_start_o === 1'b1) n_start <= n_start + 8'h01;
    if (sys_rst_i === 1'b1) n_susp <= 8'h00;
    else if (suspend_o === 1'b1) n_susp <= n_susp + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c);
    host.frame({c, 32'h0000_0000}, 8, rd_v);
  endtask
  task automatic rs(input logic [7:0] exp);
    host.frame({`CMD_RD_STATUS, 32'h0000_0000}, 16, rd_v);
    chk(rd_v, exp);
  endtask
  task automatic done(input logic f);
    @(negedge clk_i);
    op_done_i = 1'b1;
    op_fail_i = f;
    @(negedge clk_i);
    op_done_i = 1'b0;
    op_fail_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {sys_rst_i, wp_n_i} = 2'b11;
    {protect_source_select_i, addr_protected_i} = 2'b00;
    {op_done_i, op_fail_i} = 2'b00;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk(status_o, 8'h00);
    rs(8'h00);
    op(`CMD_WR_EN);
    rs(8'h02);
    op(`CMD_WR_DIS);
    rs(8'h00);
    host.frame({`CMD_PROGRAM, 24'h00_0100, 8'h5a}, 40, rd_v);
    chk(n_start, 8'h00);
    // full write: fail, latch and busy bits in the data must not land
    op(`CMD_WR_EN);
    host.frame({`CMD_WR_REGS, 8'hff, 24'h00_0000}, 16, rd_v);
    chk({6'h00, op_req_o.kind}, {6'h00, OP_REG});
    done(1'b0);
    chk(status_o, 8'h9c);
    chk({5'h00, bp_active_o}, 8'h07);
    op(`CMD_WR_EN);
    op(`CMD_BULK_ERASE);
    chk(n_start, 8'h01);
    @(negedge clk_i);
    wp_n_i = 1'b0;
    host.frame({`CMD_WR_REGS, 8'h00, 24'h00_0000}, 16, rd_v);
    rs(8'h9e);
    @(negedge clk_i);
    wp_n_i = 1'b1;
    host.frame({`CMD_WR_REGS, 8'h00, 24'h00_0000}, 16, rd_v);
    done(1'b0);
    chk(status_o, 8'h00);
    // protected program, then commands while held busy
    op(`CMD_WR_EN);
    @(negedge clk_i);
    addr_protected_i = 1'b1;
    host.frame({`CMD_PROGRAM, 24'h00_0100, 8'h5a}, 40, rd_v);
    chk(n_start, 8'h02);
    op(`CMD_WR_DIS);
    rs(8'h43);
    @(negedge clk_i);
    addr_protected_i = 1'b0;
    op(`CMD_CLR_A);
    chk(status_o & 8'h61, 8'h00);
    op(`CMD_WR_DIS);
    rs(8'h00);
    // sector erase with suspends and an engine failure
    op(`CMD_WR_EN);
    host.frame({`CMD_SECT_ERASE, 24'h04_0000, 8'h00}, 32, rd_v);
    chk({6'h00, op_req_o.kind}, {6'h00, OP_ERASE});
    chk(check_addr_o[23:16], 8'h04);
    op(`CMD_PGM_SUSP);
    chk(n_susp, 8'h00);
    op(`CMD_ERS_SUSP);
    chk(n_susp, 8'h01);
    done(1'b1);
    rs(8'h23);
    op(`CMD_CLR_B);
    chk(status_o & 8'h61, 8'h00);
    op(`CMD_WR_DIS);
    // successful program
    op(`CMD_WR_EN);
    host.frame({`CMD_PROGRAM, 24'h00_0200, 8'ha5}, 40, rd_v);
    chk(status_o, 8'h03);
    done(1'b0);
    chk(status_o, 8'h00);
    // volatile protect source: immediate, no engine, stored bits kept
    @(negedge clk_i);
    protect_source_select_i = 1'b1;
    op(`CMD_WR_EN);
    host.frame({`CMD_WR_REGS, 8'h08, 24'h00_0000}, 16, rd_v);
    chk(status_o, 8'h08);
    chk(n_start, 8'h04);
    host.frame({`CMD_RD_ANY, `ADDR_SR1_V, 8'h00}, 40, rd_v);
    chk(rd_v, 8'h08);
    @(negedge clk_i);
    protect_source_select_i = 1'b0;
    @(negedge clk_i);
    chk({5'h00, bp_active_o}, 8'h00);
    // bulk erase with the common suspend opcode
    op(`CMD_WR_EN);
    op(`CMD_BULK_ERASE);
    chk({6'h00, op_req_o.kind}, {6'h00, OP_BULK});
    op(`CMD_ANY_SUSP);
    chk(n_susp, 8'h02);
    done(1'b0);
    chk(status_o, 8'h08);
    // program failed by the engine holds busy until cleared
    op(`CMD_WR_EN);
    host.frame({`CMD_PROGRAM, 24'h00_0300, 8'h11}, 40, rd_v);
    chk(op_req_o.addr[15:8], 8'h03);
    done(1'b1);
    rs(8'h4b);
    op(`CMD_CLR_A);
    op(`CMD_WR_DIS);
    rs(8'h08);
    // any-register write of the stored copy, read back both ways
    op(`CMD_WR_EN);
    host.frame({`CMD_WR_ANY, `ADDR_SR1_NV, 8'h0c}, 40, rd_v);
    done(1'b0);
    host.frame({`CMD_RD_ANY, `ADDR_SR1_NV, 8'h00}, 40, rd_v);
    chk(rd_v, 8'h0c);
    chk(status_o, 8'h0c);
    chk(n_start, 8'h07);
    // soft reset restores stored protect bits and drops the latch
    @(negedge clk_i);
    protect_source_select_i = 1'b1;
    op(`CMD_WR_EN);
    host.frame({`CMD_WR_REGS, 8'h1c, 24'h00_0000}, 16, rd_v);
    chk({5'h00, bp_active_o}, 8'h07);
    op(`CMD_WR_EN);
    op(`CMD_SOFT_RESET);
    chk(status_o, 8'h0c);
    // hardware reset in mid-run clears the latch
    op(`CMD_WR_EN);
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    protect_source_select_i = 1'b0;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk(status_o, 8'h00);
    chk({7'h00, miso_oe_n_o}, 8'h01);
    rs(8'h00);
    finish_test();
  end
endmodule

bind flash_status_one flash_status_one_props u_props (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .op_done_i(op_done_i), .op_fail_i(op_fail_i),
  .bp_active_o(bp_active_o), .status_o(status_o), .op_req_o(op_req_o),
  .op_start_o(op_start_o), .suspend_o(suspend_o));

`default_nettype wire
